// ==== rtl/i2c_regs_map.svh ====
// Purpose: register offsets, field positions, reset values and limits
// Assumes: byte offsets on an 8-bit APB address
// Notes:   definitions only
`ifndef I2C_REGS_MAP_SVH
`define I2C_REGS_MAP_SVH

`define RAW_STATUS_OFS       8'h34
`define TX_ABORT_CLEAR_OFS   8'h54
`define SLV_TX_DONE_CLR_OFS  8'h58
`define BUSY_CLEAR_OFS       8'h5C
`define STOP_CLEAR_OFS       8'h60
`define START_CLEAR_OFS      8'h64
`define GC_CLEAR_OFS         8'h68
`define ENABLE_OFS           8'h6C
`define STATUS_OFS           8'h70
`define TX_LEVEL_OFS         8'h74
`define RX_LEVEL_OFS         8'h78
`define HOLD_OFS             8'h7C
`define SETUP_OFS            8'h94
`define GC_ACK_OFS           8'h98
`define SLV_MASK_OFS         8'hB0
`define RCV_ADDR_OFS         8'hB4

`define RAW_TX_ABORT_BIT     6
`define RAW_SLV_TX_DONE_BIT  7
`define RAW_BUSY_BIT         8
`define RAW_STOP_BIT         9
`define RAW_START_BIT        10
`define RAW_GC_BIT           11

`define EN_ENABLE_BIT        0
`define EN_ABORT_BIT         1

`define ST_ANY_BUSY_BIT      0
`define ST_TX_ROOM_BIT       1
`define ST_TX_EMPTY_BIT      2
`define ST_RX_NONEMPTY_BIT   3
`define ST_RX_FULL_BIT       4
`define ST_MST_BUSY_BIT      5
`define ST_SLV_BUSY_BIT      6

`define HOLD_RX_MSB          23
`define HOLD_RX_LSB          16
`define HOLD_TX_MSB          15
`define HOLD_TX_LSB          0

`define SETUP_RESET          8'h64
`define SETUP_MIN            8'h02
`define GC_ACK_RESET         1'b1
`define SLV_MASK_RESET       10'h3FF
`define HOLD_RX_RESET        8'h00
`define HOLD_TX_RESET        16'h0000
`define GC_ADDRESS           7'h00
`define ADDR_BITS            4'h8

`endif

// ==== rtl/i2c_regs_pkg.sv ====
// Purpose: shared types of the status, clear and timing register block
// Assumes: nothing beyond the map header
// Notes:   one-hot slave address-phase states
package i2c_regs_pkg;
   typedef enum logic [3:0] {
      SLV_IDLE = 4'b0001,
      SLV_ADDR = 4'b0010,
      SLV_ACK  = 4'b0100,
      SLV_BUSY = 4'b1000
   } slave_state_type;
endpackage

// ==== rtl/i2c_status_regs.sv ====
// Purpose: APB register side of an I2C controller: clear-on-read flags,
//          enable/abort, FIFO and FSM status, levels, SDA timing, addressing
// Assumes: scl/sda pins arrive asynchronously; engine strobes are on clk
// Notes:   FIFO storage lives in the engine; levels are tracked here
`timescale 1ns/1ps
`include "i2c_regs_map.svh"

// Operation
// RULE1: reading slave-transmit-done clear register clears raw bit 7.
// RULE2: busy clear read returns bit 8, clears only when controller idle.
// RULE3: busy flag self-clears when disabled and bus is quiet.
// RULE4: reading stop clear register clears raw bit 9.
// RULE5: reading start clear register clears raw bit 10.
// RULE6: reading general-call clear register clears raw bit 11.
// RULE7: abort set only as master, writing zero cannot clear, reads 1 meanwhile.
// RULE8: abort finishes transfer, issues STOP, flushes TX, flags abort, self-clears.
// RULE9: enable bit 0; when 0 both FIFOs held erased.
// RULE10: status bit 6 slave busy, bit 5 master busy.
// RULE11: status bits 4..1 give rx full, rx nonempty, tx empty, tx room.
// RULE12: status bit 0 is OR of master and slave busy.
// RULE13: receive level bits 1:0 count entries, 0 to 2.
// RULE14: receive SDA hold while SCL high uses hold bits 23:16.
// RULE15: transmit SDA hold after SCL falls uses hold bits 15:0.
// RULE16: setup count bits 7:0 resets 0x64; software keeps it at least 2.
// RULE17: general-call ack bit 1 acknowledges; 0 neither acks nor flags.
// RULE18: mask bit 1 compares own-address bit, 0 ignores; resets all ones.
// RULE19: received slave address captured into read-only bits 9:0.
// RULE20: after abort TX stays flushed, refuses writes until abort clear read.
// RULE21: general-call flag set when general call received and acknowledged.
// RULE22: transmit level register reports TX entry count in two bits.
module i2c_status_regs
   import i2c_regs_pkg::*;
#(
   parameter int FIFO_DEPTH = 2
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // I2C pins
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   // protocol engine
   input  wire logic        masterMode,
   input  wire logic        masterFsmBusy,
   input  wire logic        masterXferDone,
   input  wire logic        slaveTxNack,
   input  wire logic        txPush,
   input  wire logic        txPop,
   input  wire logic        rxPush,
   input  wire logic        rxPop,
   input  wire logic [9:0]  ownSlaveAddress,
   output logic             moduleEnable,
   output logic             abortActive,
   output logic             stopRequest,
   output logic             txFlushed,
   output logic [7:0]       sdaSetupCount
);

   localparam logic [1:0] DEPTH_CNT = 2'(FIFO_DEPTH);

   logic            pready_r, pslverr_r;
   logic [31:0]     prdata_r, readData;
   logic            mapped;
   logic            enable_r, abort_r, stopRequest_r, txFlushed_r;
   logic            slvTxDone_r, busyFlag_r, stopFlag_r, startFlag_r, gcFlag_r, txAbortFlag_r;
   logic [1:0]      txCount_r, rxCount_r;
   logic [7:0]      rxHold_r, setup_r;
   logic [15:0]     txHold_r;
   logic            gcAck_r;
   logic [9:0]      slvMask_r, rcvAddr_r;
   logic            sclMeta_r, sclSync_r, sclPrev_r, sdaMeta_r, sdaSync_r, sdaPrev_r;
   logic [7:0]      sclHighCnt_r;
   logic            sclRise, sclFall, startDet, stopDet, busIdle_r;
   slave_state_type slvState_r;
   logic [3:0]      bitCnt_r;
   logic [7:0]      shift_r;
   logic [15:0]     holdCnt_r;
   logic            holdArm_r, sdaOe_r;
   logic            rdStrobe, wrStrobe, byteDone, isGc, addrMatch, ackIt, slaveBusy;

   function automatic logic hit(input logic [7:0] ofs);
      return paddr == ofs;
   endfunction

   function automatic logic [1:0] level_nxt(input logic [1:0] cnt, input logic inc, input logic dec);
      logic [1:0] res;
      res = cnt;
      if (inc && !dec && cnt < DEPTH_CNT)
         res = cnt + 2'h1;
      else if (dec && !inc && cnt != 2'h0)
         res = cnt - 2'h1;
      return res;
   endfunction

   assign rdStrobe  = psel && penable && !pwrite && !pready_r;
   assign wrStrobe  = psel && penable && pwrite && !pready_r;
   assign slaveBusy = slvState_r != SLV_IDLE;

   // two-stage synchronisers, then edge history
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclMeta_r <= 1'b1;
         sclSync_r <= 1'b1;
         sclPrev_r <= 1'b1;
         sdaMeta_r <= 1'b1;
         sdaSync_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclMeta_r <= sclIn;
         sclSync_r <= sclMeta_r;
         sclPrev_r <= sclSync_r;
         sdaMeta_r <= sdaIn;
         sdaSync_r <= sdaMeta_r;
         sdaPrev_r <= sdaSync_r;
      end
   end

   assign sclRise = sclSync_r && !sclPrev_r;
   assign sclFall = !sclSync_r && sclPrev_r;

   // RULE14 receive hold qualifier
   // an SDA edge counts as START/STOP only once SCL has been high long enough
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         sclHighCnt_r <= 8'h00;
      else if (!sclSync_r)
         sclHighCnt_r <= 8'h00;
      else if (sclHighCnt_r != 8'hFF)
         sclHighCnt_r <= sclHighCnt_r + 8'h01;
   end

   assign startDet = sclSync_r && sclPrev_r && sdaPrev_r && !sdaSync_r && sclHighCnt_r >= rxHold_r;
   assign stopDet  = sclSync_r && sclPrev_r && !sdaPrev_r && sdaSync_r && sclHighCnt_r >= rxHold_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         busIdle_r <= 1'b1;
      else if (startDet)
         busIdle_r <= 1'b0;
      else if (stopDet)
         busIdle_r <= 1'b1;
   end

   // address phase decode
   assign byteDone = slvState_r == SLV_ADDR && bitCnt_r == `ADDR_BITS;
   assign isGc     = shift_r[7:1] == `GC_ADDRESS && !shift_r[0];
   // RULE18 masked compare
   assign addrMatch = ((shift_r[7:1] ^ ownSlaveAddress[6:0]) & slvMask_r[6:0]) == 7'h00;
   // RULE17 general call acked only when enabled by software
   assign ackIt = isGc ? gcAck_r : addrMatch;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slvState_r <= SLV_IDLE;
         bitCnt_r   <= 4'h0;
         shift_r    <= 8'h00;
      end else if (!enable_r || stopDet) begin
         slvState_r <= SLV_IDLE;
      end else if (startDet) begin
         slvState_r <= SLV_ADDR;
         bitCnt_r   <= 4'h0;
      end else begin
         unique case (slvState_r)
            SLV_IDLE: ;
            SLV_ADDR: begin
               if (byteDone)
                  slvState_r <= ackIt ? SLV_ACK : SLV_IDLE;
               else if (sclRise) begin
                  shift_r  <= {shift_r[6:0], sdaSync_r};
                  bitCnt_r <= bitCnt_r + 4'h1;
               end
            end
            SLV_ACK: begin
               if (holdArm_r && holdCnt_r == 16'h0000 && sdaOe_r)
                  slvState_r <= SLV_BUSY;
            end
            SLV_BUSY: ;
         endcase
      end
   end

   // RULE15 transmit hold after each SCL fall before SDA moves
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         holdArm_r <= 1'b0;
         holdCnt_r <= 16'h0000;
         sdaOe_r   <= 1'b0;
      end else if (slvState_r != SLV_ACK) begin
         holdArm_r <= 1'b0;
         sdaOe_r   <= 1'b0;
      end else if (sclFall) begin
         holdArm_r <= 1'b1;
         holdCnt_r <= txHold_r;
      end else if (holdArm_r) begin
         if (holdCnt_r == 16'h0000) begin
            holdArm_r <= 1'b0;
            sdaOe_r   <= !sdaOe_r;
         end else
            holdCnt_r <= holdCnt_r - 16'h0001;
      end
   end

   // RULE19 capture received address
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         rcvAddr_r <= 10'h000;
      else if (byteDone)
         rcvAddr_r <= {3'b000, shift_r[7:1]};
   end

   // APB writes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         enable_r  <= 1'b0;
         rxHold_r  <= `HOLD_RX_RESET;
         txHold_r  <= `HOLD_TX_RESET;
         setup_r   <= `SETUP_RESET;
         gcAck_r   <= `GC_ACK_RESET;
         slvMask_r <= `SLV_MASK_RESET;
      end else if (wrStrobe) begin
         if (hit(`ENABLE_OFS))
            enable_r <= pwdata[`EN_ENABLE_BIT];
         if (hit(`HOLD_OFS)) begin
            rxHold_r <= pwdata[`HOLD_RX_MSB:`HOLD_RX_LSB];
            txHold_r <= pwdata[`HOLD_TX_MSB:`HOLD_TX_LSB];
         end
         // RULE16 values below the minimum are raised to it
         if (hit(`SETUP_OFS))
            setup_r <= (pwdata[7:0] < `SETUP_MIN) ? `SETUP_MIN : pwdata[7:0];
         if (hit(`GC_ACK_OFS))
            gcAck_r <= pwdata[0];
         if (hit(`SLV_MASK_OFS))
            slvMask_r <= pwdata[9:0];
      end
   end

   // RULE7 abort: set as master only, cleared by hardware alone
   // RULE8 completion: STOP, flush, flag, release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         abort_r       <= 1'b0;
         stopRequest_r <= 1'b0;
      end else begin
         stopRequest_r <= 1'b0;
         if (abort_r && (masterXferDone || !masterFsmBusy)) begin
            abort_r       <= 1'b0;
            stopRequest_r <= 1'b1;
         end else if (wrStrobe && hit(`ENABLE_OFS) && pwdata[`EN_ABORT_BIT] && masterMode && enable_r)
            abort_r <= 1'b1;
      end
   end

   // RULE20 flushed TX refuses pushes until abort clear read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         txFlushed_r <= 1'b0;
      else if (abort_r && (masterXferDone || !masterFsmBusy))
         txFlushed_r <= 1'b1;
      else if (rdStrobe && hit(`TX_ABORT_CLEAR_OFS))
         txFlushed_r <= 1'b0;
   end

   // RULE9 erased while disabled
   // RULE13 receive level 0..2
   // RULE22 transmit level
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txCount_r <= 2'h0;
         rxCount_r <= 2'h0;
      end else if (!enable_r) begin
         txCount_r <= 2'h0;
         rxCount_r <= 2'h0;
      end else begin
         txCount_r <= (txFlushed_r || stopRequest_r) ? 2'h0 : level_nxt(txCount_r, txPush, txPop);
         rxCount_r <= level_nxt(rxCount_r, rxPush, rxPop);
      end
   end

   // sticky raw flags; a new event beats a clearing read in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slvTxDone_r   <= 1'b0;
         stopFlag_r    <= 1'b0;
         startFlag_r   <= 1'b0;
         gcFlag_r      <= 1'b0;
         txAbortFlag_r <= 1'b0;
      end else begin
         // RULE1 slave transmit done
         if (slaveTxNack)
            slvTxDone_r <= 1'b1;
         else if (rdStrobe && hit(`SLV_TX_DONE_CLR_OFS))
            slvTxDone_r <= 1'b0;
         // RULE4 stop flag
         if (stopDet)
            stopFlag_r <= 1'b1;
         else if (rdStrobe && hit(`STOP_CLEAR_OFS))
            stopFlag_r <= 1'b0;
         // RULE5 start flag
         if (startDet)
            startFlag_r <= 1'b1;
         else if (rdStrobe && hit(`START_CLEAR_OFS))
            startFlag_r <= 1'b0;
         // RULE21 general call acknowledged
         // RULE6 cleared by read or by disable
         if (byteDone && isGc && gcAck_r && enable_r)
            gcFlag_r <= 1'b1;
         else if (!enable_r || (rdStrobe && hit(`GC_CLEAR_OFS)))
            gcFlag_r <= 1'b0;
         if (abort_r && (masterXferDone || !masterFsmBusy))
            txAbortFlag_r <= 1'b1;
         else if (rdStrobe && hit(`TX_ABORT_CLEAR_OFS))
            txAbortFlag_r <= 1'b0;
      end
   end

   // RULE2 busy flag cleared by read only once idle
   // RULE3 hardware clear when disabled and bus quiet
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         busyFlag_r <= 1'b0;
      else if (masterFsmBusy || slaveBusy || (enable_r && startDet))
         busyFlag_r <= 1'b1;
      else if (rdStrobe && hit(`BUSY_CLEAR_OFS))
         busyFlag_r <= 1'b0;
      else if (!enable_r && busIdle_r)
         busyFlag_r <= 1'b0;
   end

   // read mux
   always_comb begin
      readData = 32'h0000_0000;
      mapped   = 1'b1;
      unique case (paddr)
         `RAW_STATUS_OFS: begin
            readData[`RAW_TX_ABORT_BIT]    = txAbortFlag_r;
            readData[`RAW_SLV_TX_DONE_BIT] = slvTxDone_r;
            readData[`RAW_BUSY_BIT]        = busyFlag_r;
            readData[`RAW_STOP_BIT]        = stopFlag_r;
            readData[`RAW_START_BIT]       = startFlag_r;
            readData[`RAW_GC_BIT]          = gcFlag_r;
         end
         `TX_ABORT_CLEAR_OFS:  readData[0] = txAbortFlag_r;
         `SLV_TX_DONE_CLR_OFS: readData[0] = slvTxDone_r;
         `BUSY_CLEAR_OFS:      readData[0] = busyFlag_r;
         `STOP_CLEAR_OFS:      readData[0] = stopFlag_r;
         `START_CLEAR_OFS:     readData[0] = startFlag_r;
         `GC_CLEAR_OFS:        readData[0] = gcFlag_r;
         `ENABLE_OFS: begin
            readData[`EN_ENABLE_BIT] = enable_r;
            readData[`EN_ABORT_BIT]  = abort_r;
         end
         // RULE10 FSM activity
         // RULE11 FIFO conditions
         // RULE12 combined activity
         `STATUS_OFS: begin
            readData[`ST_SLV_BUSY_BIT]    = slaveBusy;
            readData[`ST_MST_BUSY_BIT]    = masterFsmBusy;
            readData[`ST_RX_FULL_BIT]     = rxCount_r == DEPTH_CNT;
            readData[`ST_RX_NONEMPTY_BIT] = rxCount_r != 2'h0;
            readData[`ST_TX_EMPTY_BIT]    = txCount_r == 2'h0;
            readData[`ST_TX_ROOM_BIT]     = txCount_r != DEPTH_CNT;
            readData[`ST_ANY_BUSY_BIT]    = slaveBusy || masterFsmBusy;
         end
         `TX_LEVEL_OFS: readData[1:0] = txCount_r;
         `RX_LEVEL_OFS: readData[1:0] = rxCount_r;
         `HOLD_OFS: begin
            readData[`HOLD_RX_MSB:`HOLD_RX_LSB] = rxHold_r;
            readData[`HOLD_TX_MSB:`HOLD_TX_LSB] = txHold_r;
         end
         `SETUP_OFS:    readData[7:0] = setup_r;
         `GC_ACK_OFS:   readData[0]   = gcAck_r;
         `SLV_MASK_OFS: readData[9:0] = slvMask_r;
         `RCV_ADDR_OFS: readData[9:0] = rcvAddr_r;
         default:       mapped = 1'b0;
      endcase
   end

   // one wait state keeps every APB output registered
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else if (psel && penable && !pready_r) begin
         pready_r  <= 1'b1;
         pslverr_r <= !mapped;
         prdata_r  <= pwrite ? 32'h0000_0000 : readData;
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   assign prdata        = prdata_r;
   assign pready        = pready_r;
   assign pslverr       = pslverr_r;
   assign sdaOut        = 1'b0;
   assign sdaOe         = sdaOe_r;
   assign moduleEnable  = enable_r;
   assign abortActive   = abort_r;
   assign stopRequest   = stopRequest_r;
   assign txFlushed     = txFlushed_r;
   assign sdaSetupCount = setup_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_stop_read_clear: assert property ( // RULE4
      rdStrobe && hit(`STOP_CLEAR_OFS) && !stopDet |=> !stopFlag_r)
      else $error("stop flag survived its clearing read");
   a_busy_read_keep: assert property ( // RULE2
      rdStrobe && hit(`BUSY_CLEAR_OFS) && (slaveBusy || masterFsmBusy) |=> busyFlag_r)
      else $error("busy flag cleared while still active");
   a_abort_no_swclear: assert property ( // RULE7
      abort_r && masterFsmBusy && !masterXferDone |=> abort_r)
      else $error("abort dropped before transfer finished");
   a_abort_finish: assert property ( // RULE8
      $fell(abort_r) |-> stopRequest_r && txFlushed_r && txAbortFlag_r)
      else $error("abort ended without stop, flush and flag");
   a_fifo_erased: assert property ( // RULE9
      !enable_r |=> txCount_r == 2'h0 && rxCount_r == 2'h0)
      else $error("fifo level nonzero while disabled");
   a_status_or: assert property ( // RULE12
      rdStrobe && hit(`STATUS_OFS) |=> prdata_r[0] == (prdata_r[5] || prdata_r[6]))
      else $error("status bit 0 is not the or of busy bits");
   a_rx_range: assert property ( // RULE13
      rxCount_r <= DEPTH_CNT)
      else $error("receive level beyond depth");
   a_gc_no_ack: assert property ( // RULE17
      byteDone && isGc && !gcAck_r |=> slvState_r == SLV_IDLE ##1 !sdaOe_r)
      else $error("general call answered while disabled");
   a_tx_refused: assert property ( // RULE20
      txFlushed_r && enable_r |=> txCount_r == 2'h0)
      else $error("flushed transmit fifo took data");
   a_hold_drive: assert property ( // RULE15
      $rose(sdaOe_r) |-> $past(holdCnt_r) == 16'h0000 && $past(holdArm_r))
      else $error("sda driven before hold count expired");

   c_abort_done: cover property (stopRequest_r);
   c_gc_ack:     cover property (byteDone && isGc && gcAck_r);
   c_addr_ack:   cover property ($fell(sdaOe_r) && slvState_r == SLV_BUSY);
   c_tx_full:    cover property (txCount_r == DEPTH_CNT);

endmodule

// ==== verif/i2c_bus_master_model.sv ====
// Purpose: far-side bus master driving SCL and SDA for address frames
// Assumes: open-drain bus with pull-ups, 64 ns SCL period inside frames
// Notes:   SCL stands high between frames; acknowledge is sampled mid-high
`timescale 1ns/1ps
module i2c_bus_master_model (
   // pull-down from the device
   input  wire logic dutPull,
   // resolved bus lines
   output logic      scl,
   output logic      sda
);
   logic sdaDrive;
   logic ackSeen;

   // pull-up: any released line reads high
   assign sda = sdaDrive & ~dutPull;

   initial begin
      scl      = 1'b1;
      sdaDrive = 1'b1;
      ackSeen  = 1'b0;
   end

   // start, address byte MSB first, ack clock with SDA released, stop
   task automatic frame(input logic [7:0] addr);
      logic [8:0] bits;
      bits = {addr, 1'b1};
      // 2 ns skew keeps every line change off the bench clock edge
      #34 sdaDrive = 1'b0;
      #32 scl = 1'b0;
      for (int i = 8; i >= 0; i--) begin
         #16 sdaDrive = bits[i];
         #16 scl = 1'b1;
         #16 ackSeen = ~sda;
         #16 scl = 1'b0;
      end
      #16 sdaDrive = 1'b0;
      #16 scl = 1'b1;
      #32 sdaDrive = 1'b1;
   endtask
endmodule

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench of the status, clear and timing registers
// Assumes: one-wait-state APB, bus master model on the I2C pins
// Notes:   expectations come from small integer models of the FIFO levels
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0;
   logic        resetn, psel, penable, pwrite, pready, pslverr, errSeen;
   logic        masterMode, masterFsmBusy, sdaOe, scl, sda;
   logic        moduleEnable, abortActive, stopRequest, txFlushed;
   logic [7:0]  paddr, setupCnt, v;
   logic [31:0] pwdata, prdata, q;
   logic [31:0] lf = 32'h8FDB;
   logic [5:0]  ev;
   logic [9:0]  ownAddr;
   logic [39:0] rstTab [8];
   int          errCount = 0;
   int          checkCount = 0;
   int          txCnt = 0;
   int          rxCnt = 0;
   int          stops = 0;

   always #4 clk = ~clk;

   i2c_status_regs u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(scl),
      .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .masterMode(masterMode), .masterFsmBusy(masterFsmBusy),
      .masterXferDone(ev[4]), .slaveTxNack(ev[5]), .txPush(ev[0]), .txPop(ev[1]), .rxPush(ev[2]),
      .rxPop(ev[3]), .ownSlaveAddress(ownAddr), .moduleEnable(moduleEnable), .abortActive(abortActive),
      .stopRequest(stopRequest), .txFlushed(txFlushed), .sdaSetupCount(setupCnt));
   i2c_bus_master_model u_mst (.dutPull(sdaOe), .scl(scl), .sda(sda));

   always @(posedge clk) if (stopRequest === 1'b1) stops++;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic testDone();
      $display("checks=%0d errors=%0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      if (n == 8) errCount++;
      q = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   task automatic pulse(input int b);
      @(posedge clk);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev[b] <= 1'b0;
      if (b == 0 && txCnt < 2) txCnt++;
      if (b == 2 && rxCnt < 2) rxCnt++;
      if (b == 1 && txCnt > 0) txCnt--;
      if (b == 3 && rxCnt > 0) rxCnt--;
   endtask

   task automatic levels();
      rd(8'h74, txCnt);
      rd(8'h78, rxCnt);
      rd(8'h70, {27'h0, rxCnt == 2, rxCnt != 0, txCnt == 0, txCnt != 2, 1'b0});
   endtask

   task automatic frameChk(input logic [7:0] b, input logic ack, input logic gc, input logic [9:0] adr);
      u_mst.frame(b);
      repeat (4) @(posedge clk);
      chk(u_mst.ackSeen, ack);
      rd(8'h34, {20'h0, gc, 3'b111, 8'h0});
      rd(8'h5C, 32'h1);
      rd(8'h60, 32'h1);
      rd(8'h64, 32'h1);
      rd(8'h68, gc);
      rd(8'h34, 32'h0);
      if (ack && !gc) rd(8'hB4, adr);
   endtask

   initial begin
      #400000;
      errCount++;
      testDone();
   end

   initial begin
      rstTab = '{40'h9400000064, 40'h9800000001, 40'hB0000003FF, 40'hB400000000,
                 40'h6C00000000, 40'h7400000000, 40'h7800000000, 40'h7000000006};
      {resetn, psel, penable, pwrite, masterMode, masterFsmBusy} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      ev = 6'h00;
      ownAddr = 10'h05A;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      foreach (rstTab[i]) rd(rstTab[i][39:32], rstTab[i][31:0]);
      apb(1'b0, 8'hFC, 32'h0);
      chk(errSeen, 1'b1);
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         v = (i == 0) ? 8'h01 : lf[7:0];
         apb(1'b1, 8'h94, {24'h0, v});
         v = (v < 8'h02) ? 8'h02 : v;
         rd(8'h94, {24'h0, v});
         chk(setupCnt, v);
      end
      apb(1'b1, 8'h7C, lf);
      rd(8'h7C, lf & 32'h00FFFFFF);
      apb(1'b1, 8'h7C, 32'h0);
      apb(1'b1, 8'h6C, 32'h1);
      chk(moduleEnable, 1'b1);
      repeat (3) begin
         pulse(0);
         pulse(2);
      end
      levels();
      pulse(1);
      pulse(3);
      levels();
      apb(1'b1, 8'h6C, 32'h0);
      txCnt = 0;
      rxCnt = 0;
      levels();
      apb(1'b1, 8'h6C, 32'h1);
      frameChk(8'hB4, 1'b1, 1'b0, 10'h05A);
      apb(1'b1, 8'hB0, 32'h3FE);
      frameChk(8'hB6, 1'b1, 1'b0, 10'h05B);
      frameChk(8'h66, 1'b0, 1'b0, 10'h000);
      frameChk(8'h00, 1'b1, 1'b1, 10'h000);
      apb(1'b1, 8'h98, 32'h0);
      frameChk(8'h00, 1'b0, 1'b0, 10'h000);
      pulse(5);
      rd(8'h34, 32'h80);
      rd(8'h58, 32'h1);
      rd(8'h34, 32'h0);
      masterMode <= 1'b1;
      masterFsmBusy <= 1'b1;
      u_mst.frame(8'h66);
      rd(8'h5C, 32'h1);
      rd(8'h5C, 32'h1);
      apb(1'b1, 8'h6C, 32'h3);
      rd(8'h6C, 32'h3);
      apb(1'b1, 8'h6C, 32'h1);
      rd(8'h6C, 32'h3);
      chk(abortActive, 1'b1);
      pulse(4);
      rd(8'h6C, 32'h1);
      chk(abortActive, 1'b0);
      chk(txFlushed, 1'b1);
      chk(stops, 1);
      pulse(0);
      txCnt = 0;
      rd(8'h74, txCnt);
      rd(8'h54, 32'h1);
      chk(txFlushed, 1'b0);
      pulse(0);
      rd(8'h74, txCnt);
      masterFsmBusy <= 1'b0;
      apb(1'b1, 8'h6C, 32'h0);
      repeat (4) @(posedge clk);
      rd(8'h34, 32'h600);
      masterMode <= 1'b0;
      apb(1'b1, 8'h6C, 32'h3);
      rd(8'h6C, 32'h1);
      testDone();
   end
endmodule
